// >>> pkg/mlmb_defines.svh
// Opcode, length, timing and address constants for the instruction sequencer
`ifndef MLMB_DEFINES_SVH
`define MLMB_DEFINES_SVH
`define MLMB_OP_XOR_DIR_IMM 8'h63
`define MLMB_OP_XOR_IND 8'h66
`define MLMB_OP_ZERO_A 8'hE4
`define MLMB_OP_INVERT_A 8'hF4
`define MLMB_OP_ROTL_A 8'h23
`define MLMB_OP_ROTL_C 8'h33
`define MLMB_OP_ROTR_A 8'h03
`define MLMB_OP_ROTR_C 8'h13
`define MLMB_OP_MOV_RN_DIR 8'hA8
`define MLMB_OP_MOV_DIR_RN 8'h88
`define MLMB_OP_MOV_DIR_DIR 8'h85
`define MLMB_OP_MOV_DIR_IND 8'h86
`define MLMB_OP_MOV_IND_DIR 8'hA6
`define MLMB_OP_LOAD_DP 8'h90
`define MLMB_OP_CODE_DP 8'h93
`define MLMB_OP_CODE_PC 8'h83
`define MLMB_OP_EXT_RD_IND 8'hE2
`define MLMB_OP_EXT_RD_DP 8'hE0
`define MLMB_OP_EXT_WR_IND 8'hF2
`define MLMB_OP_EXT_WR_DP 8'hF0
`define MLMB_OP_PUSH 8'hC0
`define MLMB_OP_POP 8'hD0
`define MLMB_OP_NIBBLE_X 8'hD6
`define MLMB_OP_AND_C_BIT 8'h82
`define MLMB_OP_AND_C_NBIT 8'hB0
`define MLMB_OP_OR_C_BIT 8'h72
`define MLMB_OP_OR_C_NBIT 8'hA0
`define MLMB_OP_MOV_BIT_C 8'h92
`define MLMB_OP_MOV_C_BIT 8'hA2
`define MLMB_OP_ZERO_BIT 8'hC2
`define MLMB_OP_SET_BIT 8'hD2
`define MLMB_OP_INVERT_BIT 8'hB2
`define MLMB_OP_BR_BIT_CLR 8'h10
`define MLMB_OP_BR_BIT_HI 8'h20
`define MLMB_OP_BR_BIT_LO 8'h30
`define MLMB_OP_BR_C_HI 8'h40
`define MLMB_OP_BR_C_LO 8'h50
`define MLMB_MASK_ALL 8'hFF
`define MLMB_MASK_RN 8'hF8
`define MLMB_MASK_RI 8'hFE
`define MLMB_LEN1 2'h1
`define MLMB_LEN2 2'h2
`define MLMB_LEN3 2'h3
`define MLMB_MC1 2'h1
`define MLMB_MC2 2'h2
`define MLMB_ONE2 2'h1
`define MLMB_CLKS_PER_MC 4
`define MLMB_PC_RESET 16'h0000
`define MLMB_BITMEM_BASE 8'h20
`define MLMB_BITMEM_LAST 8'h2F
`define MLMB_BIT_SFR_MASK 8'hF8
`define MLMB_BIT_POS_W 3
`define MLMB_BIT_SFR_FLAG 7
`endif

// >>> pkg/mlmb_pkg.sv
// Types shared by the instruction sequencer and its helpers
package mlmb_pkg;
  typedef enum logic [3:0] {
    CLS_NONE, CLS_XOR, CLS_ACC_UNARY, CLS_MOVE, CLS_CODE_READ, CLS_EXT, CLS_STACK,
    CLS_NIBBLE, CLS_BOOL_CARRY, CLS_BIT_WRITE, CLS_BIT_READ, CLS_JMP_CARRY, CLS_JMP_BIT, CLS_JMP_BIT_CLR
  } mlmb_class_t;
  typedef enum logic [1:0] {ST_OPCODE, ST_OPERAND, ST_EXEC, ST_RETIRE} mlmb_state_t;
  typedef struct packed {
    mlmb_class_t cls;
    logic [1:0] len;
    logic [1:0] cycles;
    logic uses_bit;
    logic supported;
  } mlmb_dec_t;
  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] op1;
    logic [7:0] op2;
    mlmb_dec_t dec;
  } mlmb_instr_t;
  typedef struct packed {
    logic [7:0] byte_addr;
    logic [2:0] pos;
    logic in_sfr;
  } mlmb_bitref_t;
endpackage : mlmb_pkg

// >>> hdl/mlmb_op_table.sv
// Opcode lookup: class, byte length and machine-cycle count
`include "mlmb_defines.svh"
module mlmb_op_table import mlmb_pkg::*; (
  input wire logic [7:0] opcode,
  output mlmb_dec_t dec
);
  function automatic logic hit(input logic [7:0] op, input logic [7:0] base, input logic [7:0] mask);
    return (op & mask) == base;
  endfunction : hit

  function automatic mlmb_dec_t mk(input mlmb_class_t c, input logic [1:0] l, input logic [1:0] m, input logic b);
    return '{cls: c, len: l, cycles: m, uses_bit: b, supported: 1'b1};
  endfunction : mk

  always_comb begin
    dec = '{cls: CLS_NONE, len: `MLMB_LEN1, cycles: `MLMB_MC1, uses_bit: 1'b0, supported: 1'b0};
    if (hit(opcode, `MLMB_OP_XOR_DIR_IMM, `MLMB_MASK_ALL)) dec = mk(CLS_XOR, `MLMB_LEN3, `MLMB_MC2, 1'b0); // [RULE1]
    else if (hit(opcode, `MLMB_OP_XOR_IND, `MLMB_MASK_RI)) dec = mk(CLS_XOR, `MLMB_LEN1, `MLMB_MC1, 1'b0); // [RULE2]
    else if (hit(opcode, `MLMB_OP_ZERO_A, `MLMB_MASK_ALL) || hit(opcode, `MLMB_OP_INVERT_A, `MLMB_MASK_ALL) ||
             hit(opcode, `MLMB_OP_ROTL_A, `MLMB_MASK_ALL) || hit(opcode, `MLMB_OP_ROTL_C, `MLMB_MASK_ALL))
      dec = mk(CLS_ACC_UNARY, `MLMB_LEN1, `MLMB_MC1, 1'b0); // [RULE3]
    else if (hit(opcode, `MLMB_OP_ROTR_A, `MLMB_MASK_ALL) || hit(opcode, `MLMB_OP_ROTR_C, `MLMB_MASK_ALL))
      dec = mk(CLS_ACC_UNARY, `MLMB_LEN1, `MLMB_MC1, 1'b0); // [RULE4]
    else if (hit(opcode, `MLMB_OP_MOV_RN_DIR, `MLMB_MASK_RN)) dec = mk(CLS_MOVE, `MLMB_LEN2, `MLMB_MC2, 1'b0); // [RULE5]
    else if (hit(opcode, `MLMB_OP_MOV_DIR_RN, `MLMB_MASK_RN)) dec = mk(CLS_MOVE, `MLMB_LEN2, `MLMB_MC2, 1'b0); // [RULE6]
    else if (hit(opcode, `MLMB_OP_MOV_DIR_DIR, `MLMB_MASK_ALL)) dec = mk(CLS_MOVE, `MLMB_LEN3, `MLMB_MC2, 1'b0); // [RULE7]
    else if (hit(opcode, `MLMB_OP_MOV_DIR_IND, `MLMB_MASK_RI)) dec = mk(CLS_MOVE, `MLMB_LEN2, `MLMB_MC2, 1'b0); // [RULE8]
    else if (hit(opcode, `MLMB_OP_MOV_IND_DIR, `MLMB_MASK_RI)) dec = mk(CLS_MOVE, `MLMB_LEN2, `MLMB_MC2, 1'b0); // [RULE9]
    else if (hit(opcode, `MLMB_OP_LOAD_DP, `MLMB_MASK_ALL)) dec = mk(CLS_MOVE, `MLMB_LEN3, `MLMB_MC2, 1'b0); // [RULE10]
    else if (hit(opcode, `MLMB_OP_CODE_DP, `MLMB_MASK_ALL)) dec = mk(CLS_CODE_READ, `MLMB_LEN1, `MLMB_MC2, 1'b0); // [RULE11]
    else if (hit(opcode, `MLMB_OP_CODE_PC, `MLMB_MASK_ALL)) dec = mk(CLS_CODE_READ, `MLMB_LEN1, `MLMB_MC2, 1'b0); // [RULE12]
    else if (hit(opcode, `MLMB_OP_EXT_RD_IND, `MLMB_MASK_RI) || hit(opcode, `MLMB_OP_EXT_RD_DP, `MLMB_MASK_ALL) ||
             hit(opcode, `MLMB_OP_EXT_WR_IND, `MLMB_MASK_RI) || hit(opcode, `MLMB_OP_EXT_WR_DP, `MLMB_MASK_ALL))
      dec = mk(CLS_EXT, `MLMB_LEN1, `MLMB_MC2, 1'b0); // [RULE13]
    else if (hit(opcode, `MLMB_OP_PUSH, `MLMB_MASK_ALL) || hit(opcode, `MLMB_OP_POP, `MLMB_MASK_ALL))
      dec = mk(CLS_STACK, `MLMB_LEN2, `MLMB_MC2, 1'b0); // [RULE14]
    else if (hit(opcode, `MLMB_OP_NIBBLE_X, `MLMB_MASK_RI)) dec = mk(CLS_NIBBLE, `MLMB_LEN1, `MLMB_MC1, 1'b0); // [RULE15]
    else if (hit(opcode, `MLMB_OP_AND_C_BIT, `MLMB_MASK_ALL) || hit(opcode, `MLMB_OP_AND_C_NBIT, `MLMB_MASK_ALL))
      dec = mk(CLS_BOOL_CARRY, `MLMB_LEN2, `MLMB_MC2, 1'b1); // [RULE16]
    else if (hit(opcode, `MLMB_OP_OR_C_BIT, `MLMB_MASK_ALL) || hit(opcode, `MLMB_OP_OR_C_NBIT, `MLMB_MASK_ALL))
      dec = mk(CLS_BOOL_CARRY, `MLMB_LEN2, `MLMB_MC2, 1'b1); // [RULE17]
    else if (hit(opcode, `MLMB_OP_MOV_BIT_C, `MLMB_MASK_ALL)) dec = mk(CLS_BIT_WRITE, `MLMB_LEN2, `MLMB_MC2, 1'b1); // [RULE18]
    else if (hit(opcode, `MLMB_OP_MOV_C_BIT, `MLMB_MASK_ALL)) dec = mk(CLS_BIT_READ, `MLMB_LEN2, `MLMB_MC1, 1'b1); // [RULE19]
    else if (hit(opcode, `MLMB_OP_ZERO_BIT, `MLMB_MASK_ALL) || hit(opcode, `MLMB_OP_SET_BIT, `MLMB_MASK_ALL) ||
             hit(opcode, `MLMB_OP_INVERT_BIT, `MLMB_MASK_ALL))
      dec = mk(CLS_BIT_WRITE, `MLMB_LEN2, `MLMB_MC1, 1'b1); // [RULE19]
    else if (hit(opcode, `MLMB_OP_BR_BIT_CLR, `MLMB_MASK_ALL)) dec = mk(CLS_JMP_BIT_CLR, `MLMB_LEN3, `MLMB_MC2, 1'b1); // [RULE20]
    else if (hit(opcode, `MLMB_OP_BR_BIT_HI, `MLMB_MASK_ALL) || hit(opcode, `MLMB_OP_BR_BIT_LO, `MLMB_MASK_ALL))
      dec = mk(CLS_JMP_BIT, `MLMB_LEN3, `MLMB_MC2, 1'b1); // [RULE21]
    else if (hit(opcode, `MLMB_OP_BR_C_HI, `MLMB_MASK_ALL) || hit(opcode, `MLMB_OP_BR_C_LO, `MLMB_MASK_ALL))
      dec = mk(CLS_JMP_CARRY, `MLMB_LEN2, `MLMB_MC2, 1'b0); // [RULE22]
  end
endmodule : mlmb_op_table

// >>> hdl/mlmb_mc_timer.sv
// Machine-cycle timer: one tick per group of core clocks, held by stalls
module mlmb_mc_timer #(
  parameter int CLKS_PER_MC = 4
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic restart,
  input wire logic stall,
  output logic tick
);
  localparam int CNT_W = (CLKS_PER_MC > 1) ? $clog2(CLKS_PER_MC) : 1;
  localparam logic [CNT_W-1:0] LAST = CNT_W'(CLKS_PER_MC - 1);
  logic [CNT_W-1:0] cnt_q;

  assign tick = !restart && !stall && (cnt_q == LAST);

  always_ff @(posedge mclk) begin
    if (srst || restart || tick) begin
      cnt_q <= '0;
    end else if (!stall) begin
      cnt_q <= cnt_q + CNT_W'(1);
    end
  end
endmodule : mlmb_mc_timer

// >>> hdl/mlmb_decoder.sv
// Instruction sequencer for the xor/rotate, transfer and boolean instruction groups
// Functional notes
// RULE1: Xor immediate into direct byte: three bytes, two machine cycles.
// RULE2: Xor indirect memory into accumulator: one byte, one machine cycle.
// RULE3: Clear, complement, rotate left and rotate left through carry: one byte, one cycle.
// RULE4: Rotate right and rotate right through carry: one byte, one cycle.
// RULE5: Move direct byte into bank register: two bytes, two cycles.
// RULE6: Move bank register into direct byte: two bytes, two cycles.
// RULE7: Move direct byte to direct byte: three bytes, two cycles.
// RULE8: Move indirect memory to direct byte: two bytes, two cycles.
// RULE9: Move direct byte to indirect memory: two bytes, two cycles.
// RULE10: Load data pointer with 16-bit constant: three bytes, two cycles.
// RULE11: Code table read via accumulator plus data pointer: one byte, two cycles.
// RULE12: Code table read via accumulator plus program counter: one byte, two cycles.
// RULE13: All external data transfers, either pointer, either direction: one byte, two cycles.
// RULE14: Stack store and restore of direct byte: two bytes, two cycles.
// RULE15: Low nibble exchange with indirect memory: one byte, one cycle.
// RULE16: And of bit or inverted bit into carry: two bytes, two cycles.
// RULE17: Or of bit or inverted bit into carry: two bytes, two cycles.
// RULE18: Copy carry into direct bit: two bytes, two cycles.
// RULE19: Bit into carry, clear, set, complement bit: two bytes, one cycle.
// RULE20: Branch on set bit and clear it: three bytes, two cycles.
// RULE21: Branch on direct bit set or clear: three bytes, two cycles.
// RULE22: Branch on carry set or clear: two bytes, two cycles.
// RULE23: Machine cycle is four core clocks, stretched by stalls.
// RULE24: Relative operand is signed 8-bit offset added to program counter.
// RULE25: Bit operands map to bytes 20h-2Fh or SFRs ending 0h/8h.
// RULE26: Exactly the instruction length in bytes is consumed before the next opcode.
`include "mlmb_defines.svh"
module mlmb_decoder import mlmb_pkg::*; #(
  parameter int CLKS_PER_MC = `MLMB_CLKS_PER_MC
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic fetch_valid,
  input wire logic [7:0] fetch_byte,
  input wire logic mc_stall,
  input wire logic carry_in,
  input wire logic bit_in,
  output logic fetch_ready,
  output logic [15:0] pc,
  output logic busy,
  output mlmb_instr_t instr,
  output mlmb_bitref_t bit_ref,
  output logic retire_valid,
  output logic retire_taken,
  output logic [15:0] retire_target,
  output logic bit_clear
);
  mlmb_state_t state_q, state_d;
  mlmb_dec_t dec_now;
  mlmb_instr_t instr_q;
  mlmb_bitref_t bitref_q;
  logic [15:0] pc_q;
  logic [15:0] rel_target;
  logic [15:0] target_q;
  logic [1:0] need_q;
  logic [1:0] mc_left_q;
  logic [7:0] rel;
  logic first_q;
  logic ready_q;
  logic busy_q;
  logic retire_q;
  logic taken_q;
  logic clear_q;
  logic accept;
  logic mc_tick;
  logic exec_done;
  logic jump_cond;

  mlmb_op_table u_table (
    .opcode(fetch_byte),
    .dec(dec_now)
  );

  // Timer held in reset outside execution so each instruction starts aligned
  mlmb_mc_timer #(
    .CLKS_PER_MC(CLKS_PER_MC)
  ) u_timer (
    .mclk(mclk),
    .srst(srst),
    .restart(state_q != ST_EXEC),
    .stall(mc_stall),
    .tick(mc_tick)
  );

  assign accept = fetch_valid && ready_q;
  assign exec_done = (state_q == ST_EXEC) && mc_tick && (mc_left_q == `MLMB_ONE2); // [RULE23]

  function automatic mlmb_bitref_t map_bit(input logic [7:0] b);
    mlmb_bitref_t r;
    r.pos = b[`MLMB_BIT_POS_W-1:0];
    r.in_sfr = b[`MLMB_BIT_SFR_FLAG];
    if (r.in_sfr) begin
      r.byte_addr = b & `MLMB_BIT_SFR_MASK;
    end else begin
      r.byte_addr = `MLMB_BITMEM_BASE | (b >> `MLMB_BIT_POS_W);
    end
    return r;
  endfunction : map_bit

  // Branch decision and target
  always_comb begin
    rel = (instr_q.dec.cls == CLS_JMP_CARRY) ? instr_q.op1 : instr_q.op2;
    rel_target = pc_q + {{8{rel[7]}}, rel}; // [RULE24]
    case (instr_q.dec.cls)
      CLS_JMP_CARRY: jump_cond = carry_in ^ (instr_q.opcode == `MLMB_OP_BR_C_LO); // [RULE22]
      CLS_JMP_BIT: jump_cond = bit_in ^ (instr_q.opcode == `MLMB_OP_BR_BIT_LO); // [RULE21]
      CLS_JMP_BIT_CLR: jump_cond = bit_in; // [RULE20]
      default: jump_cond = 1'b0;
    endcase
  end

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_OPCODE: begin
        if (accept) begin
          state_d = (dec_now.len == `MLMB_LEN1) ? ST_EXEC : ST_OPERAND; // [RULE26]
        end
      end
      ST_OPERAND: begin
        if (accept && need_q == `MLMB_ONE2) begin
          state_d = ST_EXEC; // [RULE26]
        end
      end
      ST_EXEC: begin
        if (exec_done) begin
          state_d = ST_RETIRE;
        end
      end
      ST_RETIRE: begin
        state_d = ST_OPCODE;
      end
      default: begin
        state_d = ST_OPCODE;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      state_q <= ST_OPCODE;
      ready_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      state_q <= state_d;
      ready_q <= (state_d == ST_OPCODE) || (state_d == ST_OPERAND);
      busy_q <= state_d != ST_OPCODE;
    end
  end

  // Instruction capture
  always_ff @(posedge mclk) begin
    if (srst) begin
      instr_q <= '0;
      need_q <= '0;
      first_q <= 1'b0;
    end else if (accept && state_q == ST_OPCODE) begin
      instr_q.opcode <= fetch_byte;
      instr_q.op1 <= '0;
      instr_q.op2 <= '0;
      instr_q.dec <= dec_now;
      need_q <= dec_now.len - `MLMB_ONE2; // [RULE26]
      first_q <= 1'b1;
    end else if (accept && state_q == ST_OPERAND) begin
      if (first_q) begin
        instr_q.op1 <= fetch_byte;
      end else begin
        instr_q.op2 <= fetch_byte;
      end
      need_q <= need_q - `MLMB_ONE2;
      first_q <= 1'b0;
    end
  end

  // Bit operand address, first operand byte only
  always_ff @(posedge mclk) begin
    if (srst) begin
      bitref_q <= '0;
    end else if (accept && state_q == ST_OPERAND && first_q && instr_q.dec.uses_bit) begin
      bitref_q <= map_bit(fetch_byte); // [RULE25]
    end
  end

  // Machine cycles left in execution
  always_ff @(posedge mclk) begin
    if (srst) begin
      mc_left_q <= '0;
    end else if (accept && state_q == ST_OPCODE) begin
      mc_left_q <= dec_now.cycles; // [RULE23]
    end else if (state_q == ST_EXEC && mc_tick) begin
      mc_left_q <= mc_left_q - `MLMB_ONE2;
    end
  end

  // Program counter: one per consumed byte, relative jump at retire
  always_ff @(posedge mclk) begin
    if (srst) begin
      pc_q <= `MLMB_PC_RESET;
    end else if (accept) begin
      pc_q <= pc_q + 16'h0001; // [RULE26]
    end else if (exec_done && jump_cond) begin
      pc_q <= rel_target; // [RULE24]
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      retire_q <= 1'b0;
      taken_q <= 1'b0;
      target_q <= '0;
      clear_q <= 1'b0;
    end else begin
      retire_q <= exec_done;
      if (exec_done) begin
        taken_q <= jump_cond;
        target_q <= jump_cond ? rel_target : pc_q;
      end
      clear_q <= exec_done && jump_cond && (instr_q.dec.cls == CLS_JMP_BIT_CLR); // [RULE20]
    end
  end

  assign fetch_ready = ready_q;
  assign pc = pc_q;
  assign busy = busy_q;
  assign instr = instr_q;
  assign bit_ref = bitref_q;
  assign retire_valid = retire_q;
  assign retire_taken = taken_q;
  assign retire_target = target_q;
  assign bit_clear = clear_q;

  // Checking helpers
  logic [7:0] exec_clks_q;
  logic stall_seen_q;
  logic [1:0] bytes_q;
  logic [15:0] pc_start_q;

  always_ff @(posedge mclk) begin
    if (srst || state_q != ST_EXEC) begin
      exec_clks_q <= '0;
      stall_seen_q <= 1'b0;
    end else begin
      exec_clks_q <= exec_clks_q + 8'h01;
      stall_seen_q <= stall_seen_q || mc_stall;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      bytes_q <= '0;
      pc_start_q <= '0;
    end else if (accept && state_q == ST_OPCODE) begin
      bytes_q <= `MLMB_ONE2;
      pc_start_q <= pc_q;
    end else if (accept) begin
      bytes_q <= bytes_q + `MLMB_ONE2;
    end
  end

  a_xor_direct_len: assert property (@(posedge mclk) disable iff (srst) // [RULE1]
    retire_q && instr_q.opcode == `MLMB_OP_XOR_DIR_IMM |-> bytes_q == `MLMB_LEN3 && instr_q.dec.cycles == `MLMB_MC2)
    else $error("xor immediate to direct byte has wrong length or cycles");

  a_xor_indirect_len: assert property (@(posedge mclk) disable iff (srst) // [RULE2]
    retire_q && (instr_q.opcode & `MLMB_MASK_RI) == `MLMB_OP_XOR_IND |-> bytes_q == `MLMB_LEN1 &&
    instr_q.dec.cycles == `MLMB_MC1)
    else $error("xor indirect has wrong length or cycles");

  a_acc_left_len: assert property (@(posedge mclk) disable iff (srst) // [RULE3]
    retire_q && (instr_q.opcode == `MLMB_OP_ZERO_A || instr_q.opcode == `MLMB_OP_ROTL_C) |->
    bytes_q == `MLMB_LEN1 && instr_q.dec.cycles == `MLMB_MC1)
    else $error("accumulator clear or left rotate has wrong timing");

  a_rotate_right_len: assert property (@(posedge mclk) disable iff (srst) // [RULE4]
    retire_q && (instr_q.opcode == `MLMB_OP_ROTR_A || instr_q.opcode == `MLMB_OP_ROTR_C) |->
    bytes_q == `MLMB_LEN1 && instr_q.dec.cls == CLS_ACC_UNARY)
    else $error("right rotate has wrong decode");

  a_move_dir_dir: assert property (@(posedge mclk) disable iff (srst) // [RULE7]
    retire_q && instr_q.opcode == `MLMB_OP_MOV_DIR_DIR |-> pc_q == pc_start_q + 16'h0003)
    else $error("direct to direct move did not consume three bytes");

  a_code_read_len: assert property (@(posedge mclk) disable iff (srst) // [RULE11]
    state_q == ST_OPCODE && accept && fetch_byte == `MLMB_OP_CODE_DP |=> state_q == ST_EXEC && mc_left_q == `MLMB_MC2)
    else $error("code table read not one byte two cycles");

  a_ext_len: assert property (@(posedge mclk) disable iff (srst) // [RULE13]
    retire_q && instr_q.dec.cls == CLS_EXT |-> bytes_q == `MLMB_LEN1 && instr_q.dec.cycles == `MLMB_MC2)
    else $error("external transfer has wrong length or cycles");

  a_bit_copy_len: assert property (@(posedge mclk) disable iff (srst) // [RULE19]
    retire_q && instr_q.opcode == `MLMB_OP_MOV_C_BIT |-> bytes_q == `MLMB_LEN2 && instr_q.dec.cycles == `MLMB_MC1)
    else $error("bit to carry copy has wrong timing");

  a_bit_jump_len: assert property (@(posedge mclk) disable iff (srst) // [RULE21]
    retire_q && instr_q.dec.cls == CLS_JMP_BIT |-> bytes_q == `MLMB_LEN3 && instr_q.dec.cycles == `MLMB_MC2)
    else $error("bit branch has wrong length or cycles");

  a_carry_jump_len: assert property (@(posedge mclk) disable iff (srst) // [RULE22]
    retire_q && instr_q.dec.cls == CLS_JMP_CARRY |-> bytes_q == `MLMB_LEN2 && !clear_q)
    else $error("carry branch has wrong length or cleared a bit");

  a_bit_clear_taken: assert property (@(posedge mclk) disable iff (srst) // [RULE20]
    clear_q |-> retire_q && taken_q && instr_q.opcode == `MLMB_OP_BR_BIT_CLR)
    else $error("bit clear issued without a taken clearing branch");

  a_exec_clocks: assert property (@(posedge mclk) disable iff (srst) // [RULE23]
    exec_done && !stall_seen_q |-> int'(exec_clks_q) + 1 == int'(instr_q.dec.cycles) * CLKS_PER_MC)
    else $error("machine cycle length differs from core clock count");

  a_rel_target: assert property (@(posedge mclk) disable iff (srst) // [RULE24]
    retire_q && taken_q |-> target_q == $past(pc_q) + {{8{rel[7]}}, rel} && pc_q == target_q)
    else $error("relative branch target wrong");

  a_bit_map: assert property (@(posedge mclk) disable iff (srst) // [RULE25]
    retire_q && instr_q.dec.uses_bit |-> (bitref_q.in_sfr ? bitref_q.byte_addr[2:0] == 3'h0 :
    (bitref_q.byte_addr >= `MLMB_BITMEM_BASE && bitref_q.byte_addr <= `MLMB_BITMEM_LAST)))
    else $error("bit operand mapped outside addressable bytes");

  a_byte_count: assert property (@(posedge mclk) disable iff (srst) // [RULE26]
    retire_q && !taken_q |-> bytes_q == instr_q.dec.len && pc_q == pc_start_q + 16'(instr_q.dec.len))
    else $error("consumed bytes differ from instruction length");

  a_move_reg_len: assert property (@(posedge mclk) disable iff (srst) // [RULE5] [RULE6]
    retire_q && ((instr_q.opcode & `MLMB_MASK_RN) == `MLMB_OP_MOV_RN_DIR ||
    (instr_q.opcode & `MLMB_MASK_RN) == `MLMB_OP_MOV_DIR_RN) |->
    bytes_q == `MLMB_LEN2 && instr_q.dec.cycles == `MLMB_MC2)
    else $error("bank register move has wrong length or cycles");

  a_move_ind_len: assert property (@(posedge mclk) disable iff (srst) // [RULE8] [RULE9]
    retire_q && ((instr_q.opcode & `MLMB_MASK_RI) == `MLMB_OP_MOV_DIR_IND ||
    (instr_q.opcode & `MLMB_MASK_RI) == `MLMB_OP_MOV_IND_DIR) |->
    bytes_q == `MLMB_LEN2 && instr_q.dec.cycles == `MLMB_MC2)
    else $error("indirect move has wrong length or cycles");

  a_load_dp_len: assert property (@(posedge mclk) disable iff (srst) // [RULE10]
    retire_q && instr_q.opcode == `MLMB_OP_LOAD_DP |-> bytes_q == `MLMB_LEN3 && instr_q.dec.cycles == `MLMB_MC2)
    else $error("data pointer load has wrong length or cycles");

  a_code_pc_len: assert property (@(posedge mclk) disable iff (srst) // [RULE12]
    retire_q && instr_q.opcode == `MLMB_OP_CODE_PC |-> bytes_q == `MLMB_LEN1 && instr_q.dec.cycles == `MLMB_MC2)
    else $error("code read via program counter has wrong length or cycles");

  a_stack_len: assert property (@(posedge mclk) disable iff (srst) // [RULE14]
    retire_q && instr_q.dec.cls == CLS_STACK |-> bytes_q == `MLMB_LEN2 && instr_q.dec.cycles == `MLMB_MC2)
    else $error("stack transfer has wrong length or cycles");

  a_nibble_len: assert property (@(posedge mclk) disable iff (srst) // [RULE15]
    retire_q && (instr_q.opcode & `MLMB_MASK_RI) == `MLMB_OP_NIBBLE_X |->
    bytes_q == `MLMB_LEN1 && instr_q.dec.cycles == `MLMB_MC1)
    else $error("low nibble exchange has wrong length or cycles");

  a_bool_carry_len: assert property (@(posedge mclk) disable iff (srst) // [RULE16] [RULE17]
    retire_q && instr_q.dec.cls == CLS_BOOL_CARRY |-> bytes_q == `MLMB_LEN2 && instr_q.dec.cycles == `MLMB_MC2)
    else $error("carry and or or with bit has wrong length or cycles");

  a_carry_to_bit: assert property (@(posedge mclk) disable iff (srst) // [RULE18]
    retire_q && instr_q.opcode == `MLMB_OP_MOV_BIT_C |-> bytes_q == `MLMB_LEN2 && instr_q.dec.cycles == `MLMB_MC2)
    else $error("carry to bit copy has wrong length or cycles");
endmodule : mlmb_decoder

// >>> test/tb_mcu_logic_move_bool_exec.sv
// Self-checking bench for the instruction sequencer: lengths, timing, branches, bit map
module tb_mcu_logic_move_bool_exec;
  timeunit 1ns;
  timeprecision 1ps;
  import mlmb_pkg::*;
  localparam int CPM = 2;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic fetch_valid = 1'b0;
  logic [7:0] fetch_byte = 8'h00;
  logic mc_stall = 1'b0;
  logic carry_in = 1'b0;
  logic bit_in = 1'b0;
  logic fetch_ready;
  logic [15:0] pc;
  logic busy;
  mlmb_instr_t instr;
  mlmb_bitref_t bit_ref;
  logic retire_valid;
  logic retire_taken;
  logic [15:0] retire_target;
  logic bit_clear;
  int n_mismatch = 0;
  int tests_run = 0;
  logic [15:0] pc_m;
  logic c_nx;
  logic b_nx;
  // Entry: opcode, fixed-bit mask, {len, cycles}
  logic [19:0] tbl [0:36] = '{
    20'h63FFE, 20'h66FE5,
    20'hE4FF5, 20'hF4FF5, 20'h23FF5, 20'h33FF5, 20'h03FF5, 20'h13FF5,
    20'hA8F8A, 20'h88F8A, 20'h85FFE, 20'h86FEA, 20'hA6FEA,
    20'h90FFE, 20'h93FF6, 20'h83FF6,
    20'hE2FE6, 20'hE0FF6, 20'hF2FE6, 20'hF0FF6, 20'hC0FFA, 20'hD0FFA, 20'hD6FE5,
    20'h82FFA, 20'hB0FFA, 20'h72FFA, 20'hA0FFA, 20'h92FFA,
    20'hA2FF9, 20'hC2FF9, 20'hD2FF9, 20'hB2FF9,
    20'h10FFE, 20'h20FFE, 20'h30FFE, 20'h40FFA, 20'h50FFA
  };

  always #5 mclk = ~mclk;

  mlmb_decoder #(.CLKS_PER_MC(CPM)) u_dut (
    .mclk(mclk), .srst(srst), .fetch_valid(fetch_valid), .fetch_byte(fetch_byte), .mc_stall(mc_stall),
    .carry_in(carry_in), .bit_in(bit_in), .fetch_ready(fetch_ready), .pc(pc), .busy(busy), .instr(instr),
    .bit_ref(bit_ref), .retire_valid(retire_valid), .retire_taken(retire_taken),
    .retire_target(retire_target), .bit_clear(bit_clear)
  );

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : tally_and_finish

  // Offer a byte until the sequencer takes it
  task automatic send(input logic [7:0] b);
    int k;
    k = 0;
    @(negedge mclk);
    while (fetch_ready !== 1'b1 && k < 100) begin
      @(negedge mclk);
      k++;
    end
    fetch_valid = 1'b1;
    fetch_byte = b;
    carry_in = c_nx;
    bit_in = b_nx;
    @(posedge mclk);
    pc_m = pc_m + 16'h0001;
  endtask : send

  task automatic run_one(input logic [19:0] e, input bit stall);
    logic [7:0] op;
    logic [7:0] b1;
    logic [7:0] b2;
    logic [7:0] rel;
    logic [7:0] ba;
    logic [1:0] len;
    logic [1:0] cyc;
    logic tk;
    logic bop;
    logic [15:0] tgt;
    int n;
    op = e[19:12] | (~e[11:4] & 8'($urandom));
    len = e[3:2];
    cyc = e[1:0];
    b1 = 8'($urandom);
    b2 = 8'($urandom);
    c_nx = 1'($urandom);
    b_nx = 1'($urandom);
    n = 0;
    send(op);
    if (len > 2'h1) send(b1);
    if (len > 2'h2) send(b2);
    @(negedge mclk);
    fetch_valid = 1'b1;
    fetch_byte = ~b2;
    mc_stall = stall;
    while (n < 60) begin
      @(posedge mclk);
      n++;
      #1;
      if (retire_valid === 1'b1) break;
      if (n == 1) check(16'(busy), 16'h0001);
      if (n == 3) begin
        @(negedge mclk);
        mc_stall = 1'b0;
      end
    end
    case (op)
      8'h40: tk = c_nx;
      8'h50: tk = ~c_nx;
      8'h10, 8'h20: tk = b_nx;
      8'h30: tk = ~b_nx;
      default: tk = 1'b0;
    endcase
    rel = (op == 8'h40 || op == 8'h50) ? b1 : b2;
    tgt = tk ? pc_m + {{8{rel[7]}}, rel} : pc_m;
    ba = b1[7] ? (b1 & 8'hF8) : (8'h20 | (b1 >> 3));
    check(16'(n), 16'(cyc * CPM + (stall ? 3 : 0)));
    check(16'(instr.dec.len), 16'(len));
    check(16'(instr.dec.cycles), 16'(cyc));
    check(16'(instr.dec.supported), 16'(op != 8'hA5));
    check({instr.opcode, instr.op1}, {op, (len > 2'h1) ? b1 : 8'h00});
    check(16'(instr.op2), 16'((len > 2'h2) ? b2 : 8'h00));
    check(16'(retire_taken), 16'(tk));
    check(retire_target, tgt);
    check(16'(bit_clear), 16'(op == 8'h10 && tk));
    bop = op inside {8'h82, 8'hB0, 8'h72, 8'hA0, 8'h92, 8'hA2, 8'hC2, 8'hD2, 8'hB2, 8'h10, 8'h20, 8'h30};
    check(16'(instr.dec.uses_bit), 16'(bop));
    if (bop) check(16'(bit_ref), 16'({ba, b1[2:0], b1[7]}));
    @(posedge mclk);
    #1;
    check(pc, tgt);
    check(16'({retire_valid, bit_clear, fetch_ready}), 16'h0001);
    pc_m = tgt;
  endtask : run_one

  initial begin
    repeat (20000) @(posedge mclk);
    n_mismatch++;
    $display("[FAIL] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
    tally_and_finish();
  end

  initial begin
    void'($urandom(32'h5366B955));
    repeat (5) @(posedge mclk);
    #1;
    check({pc[14:0], fetch_ready}, 16'h0000);
    @(negedge mclk);
    srst = 1'b0;
    pc_m = 16'h0000;
    for (int p = 0; p < 2; p++) begin
      foreach (tbl[i]) run_one(tbl[i], p == 1);
      $display("table pass %0d done", p);
    end
    run_one(20'hA5FF5, 1'b0);
    $display("unsupported opcode test done");
    @(negedge mclk);
    srst = 1'b1;
    fetch_valid = 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    check({pc[13:0], busy, fetch_ready}, 16'h0000);
    @(negedge mclk);
    srst = 1'b0;
    pc_m = 16'h0000;
    run_one(tbl[0], 1'b0);
    $display("mid-run reset test done");
    tally_and_finish();
  end
endmodule : tb_mcu_logic_move_bool_exec
